/* acd_chk.sv */
`timescale 1ns/1ps
module acd_chk
   import acd_pkg::*;
#(
   parameter int CHANNELS = 4
) (
   input wire logic                                clk,
   input wire logic                                resetn,
   input wire logic                                ce,
   input wire logic                                link_scl,
   input wire logic                                sda_i,
   input wire logic                                sda_o,
   input wire logic                                sda_oe,
   input wire acd_pkg::acd_fault_t [CHANNELS-1:0] fault_i,
   input wire logic                                thermal_warn_i,
   input wire logic                                turnon_done_i,
   input wire logic                                clip_raw_i,
   input wire logic                                offset_raw_i,
   input wire acd_pkg::acd_ctrl_t                 ctrl_o,
   input wire logic                                clip_detector
);
   logic [2:0] src_w;
   logic       sel_w;
   assign src_w = {ctrl_o.pin_offset, clip_raw_i, offset_raw_i};
   assign sel_w = ctrl_o.pin_offset ? offset_raw_i : clip_raw_i;
   // Link edges are sampled as data in the system domain, so one clock serves all
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   a_drain_only: assert property (sda_o == 1'b0)
      else $error("data line driven high");
   a_oe_on_fall: assert property ($changed(sda_oe) |-> !link_scl)
      else $error("data drive changed while bus clock high");
   a_oe_full_bit: assert property ($rose(sda_oe) |-> sda_oe [*7])
      else $error("data drive shorter than one bit");
   a_idle_release: assert property (link_scl [*6] |-> !sda_oe)
      else $error("data line held with bus idle");
   a_start_quiet: assert property ($fell(sda_i) && link_scl |-> !sda_oe [*8])
      else $error("drive during address after start");
   a_ctrl_in_ack: assert property ($changed(ctrl_o) |-> sda_oe)
      else $error("control changed outside acknowledge");
   a_ctrl_paired: assert property ($changed(ctrl_o) |=> $stable(ctrl_o) [*8])
      else $error("control bytes applied apart");
   // Indicator pipeline only moves while enabled
   a_clip_route: assert property (($stable(src_w) && ce) [*5] |-> clip_detector == sel_w)
      else $error("indicator source wrong");
   c_write: cover property ($changed(ctrl_o));
   c_drive: cover property ($rose(sda_oe));
   c_clip: cover property ($rose(clip_detector));
endmodule : acd_chk

bind acd_port acd_chk #(.CHANNELS(CHANNELS)) chk_u (.*);

/* acd_consts.svh */
`ifndef ACD_CONSTS_SVH
`define ACD_CONSTS_SVH

// Bus address byte; bit 0 is the direction and is excluded from the match
`define ACD_ADDR_BYTE     8'hD8
`define ACD_RW_BIT        0

// Instruction byte one fields
`define ACD_IB1_DIAG_RPT  7
`define ACD_IB1_DIAG_EN   6
`define ACD_IB1_OFS_EN    5
`define ACD_IB1_GAIN_F    4
`define ACD_IB1_GAIN_R    3
`define ACD_IB1_UNMUTE_F  2
`define ACD_IB1_UNMUTE_R  1
`define ACD_IB1_CLIP_LVL  0

// Instruction byte two fields
`define ACD_IB2_CUR_THR   7
`define ACD_IB2_FAST_MUTE 6
`define ACD_IB2_PIN_OFS   5
`define ACD_IB2_RUN       4
`define ACD_IB2_LINE_DIAG 3
`define ACD_IB2_CUR_EN    2
`define ACD_IB2_LOWQ_F    1
`define ACD_IB2_LOWQ_R    0

// Diagnostic byte fields
`define ACD_DB_THERM      7
`define ACD_DB_DONE       6
`define ACD_DB_CUR        5
`define ACD_DB_SRC        4
`define ACD_DB_SLOAD      3
`define ACD_DB_OPEN       2
`define ACD_DB_SVCC       1
`define ACD_DB_SGND       0

// Reset values and fixed figures
`define ACD_IB1_RST       8'h00
`define ACD_IB2_RST       8'h00
`define ACD_DB_RST        8'h00
`define ACD_FILL_BYTE     8'hFF
`define ACD_DB_COUNT      4
`define ACD_WR_BYTES      2
`define ACD_BIT_LAST      4'h7
`define ACD_BIT_ACK       4'h8

`endif

/* acd_host.sv */
`timescale 1ns/1ps
module acd_host (
   output logic      scl,
   output logic      sda_drv,
   input  wire logic sda
);
   // Released lines sit high through the pull-up; clock stands still between frames unless idle_clocks runs it
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // Data moves only while the clock is low; only start and stop move it while high
   task automatic bit_cycle(input logic b, output logic r);
      sda_drv = b;
      #20 scl = 1'b1;
      #20 r = sda;
      #20 scl = 1'b0;
      #20;
   endtask : bit_cycle
   task automatic idle_clocks(input int n);
      logic r;
      repeat (n) bit_cycle(1'b1, r);
   endtask : idle_clocks
   task automatic start_cond();
      sda_drv = 1'b1;
      // The port only sees a start after a rising edge with the line high
      #20 scl = 1'b0;
      #20 scl = 1'b1;
      #20 sda_drv = 1'b0;
      #20 scl = 1'b0;
      #20;
   endtask : start_cond
   task automatic stop_cond();
      sda_drv = 1'b0;
      #20 scl = 1'b1;
      #20 sda_drv = 1'b1;
      #40;
   endtask : stop_cond
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_cycle(d[i], r);
      bit_cycle(1'b1, r);
      ack = ~r;
   endtask : send_byte
   task automatic recv_byte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b1, r);
         d[i] = r;
      end
      bit_cycle(~more, r);
   endtask : recv_byte
endmodule : acd_host

/* acd_pkg.sv */
package acd_pkg;

   // Field order matches {instruction_byte_one, instruction_byte_two}
   typedef struct packed {
      logic diag_repeat;
      logic diag_enable;
      logic offset_enable;
      logic gain_front_12db;
      logic gain_rear_12db;
      logic unmute_front;
      logic unmute_rear;
      logic clip_10pct;
      logic cur_thr_300ma;
      logic fast_mute;
      logic pin_offset;
      logic amp_run;
      logic line_diag;
      logic cur_det_en;
      logic lowq_front;
      logic lowq_rear;
   } acd_ctrl_t;

   typedef struct packed {
      logic short_gnd;
      logic short_vcc;
      logic short_load;
      logic open_load;
      logic offset;
      logic cur_low;
   } acd_fault_t;

   typedef enum logic [3:0] {
      ACD_IDLE  = 4'b0001,
      ACD_ADDR  = 4'b0010,
      ACD_WRITE = 4'b0100,
      ACD_READ  = 4'b1000
   } acd_state_t;

endpackage : acd_pkg

/* acd_port.sv */
`timescale 1ns/1ps
`include "acd_consts.svh"
module acd_port
   import acd_pkg::*;
#(
   parameter int CHANNELS = `ACD_DB_COUNT
) (
   input  wire logic                        clk,
   input  wire logic                        resetn,
   input  wire logic                        ce,
   input  wire logic                        link_scl,
   input  wire logic                        sda_i,
   output logic                             sda_o,
   output logic                             sda_oe,
   input  wire acd_pkg::acd_fault_t [CHANNELS-1:0] fault_i,
   input  wire logic                        thermal_warn_i,
   input  wire logic                        turnon_done_i,
   input  wire logic                        clip_raw_i,
   input  wire logic                        offset_raw_i,
   output acd_pkg::acd_ctrl_t               ctrl_o,
   output logic                             clip_detector
);
   import acd_pkg::*;

   localparam logic [7:0] ADDR_BYTE = `ACD_ADDR_BYTE;
   localparam int         FLT_W     = CHANNELS * $bits(acd_fault_t);
   localparam int         SYNC_W    = FLT_W + 6;

   // ---------------- Link domain: runs on the bus clock ----------------
   logic [1:0]       lk_sync;
   logic             lk_rst_n;
   logic             lk_ce;
   logic             sda_pos_q;
   acd_state_t       state_q;
   acd_state_t       state_d;
   logic [3:0]       cnt_q;
   logic [3:0]       cnt_d;
   logic [7:0]       shift_q;
   logic [7:0]       shift_d;
   logic [1:0]       idx_q;
   logic [1:0]       idx_d;
   logic [1:0]       nidx;
   logic             oe_q;
   logic             oe_d;
   logic             busy_q;
   logic             busy_d;
   logic [7:0]       stage_q;
   logic [7:0]       stage_d;
   logic [7:0]       lk_ib1_q;
   logic [7:0]       lk_ib1_d;
   logic [7:0]       lk_ib2_q;
   logic [7:0]       lk_ib2_d;
   logic             tgl_q;
   logic             tgl_d;
   logic             start_seen;
   logic             stop_seen;
   logic [7:0]       byte_in;

   // ---------------- System domain ----------------
   logic [SYNC_W-1:0] sync_q;
   acd_fault_t [CHANNELS-1:0] flt_s;
   logic             therm_s;
   logic             done_s;
   logic             clip_s;
   logic             ofs_s;
   logic             tgl_s;
   logic             busy_s;
   logic             tgl_seen_q;
   logic             busy_prev_q;
   logic             read_end;
   logic [7:0]       ib1_q;
   logic [7:0]       ib2_q;
   logic             diag_done;
   logic [7:0]       snap_q [CHANNELS];
   logic [7:0]       db_now [CHANNELS];
   logic [CHANNELS-1:0] seen_q;
   logic             out_en_q;

   acd_sync #(.WIDTH(2)) u_link_sync (
      .clk (link_scl),
      .en  (1'b1),
      .d   ({resetn, ce}),
      .q   (lk_sync)
   );

   assign lk_rst_n = lk_sync[1];
   assign lk_ce    = lk_sync[0];

   // Bus level while the clock is high; compared at the falling edge
   always_ff @(posedge link_scl) begin
      if (!lk_rst_n) begin
         sda_pos_q <= 1'b1;
      end else if (lk_ce) begin
         sda_pos_q <= sda_i;
      end
   end

   // Data may only move while the clock is low, so a change while high
   // is a start or a stop; a stop with no later falling edge is harmless
   // because every frame opens with a fresh start.
   assign start_seen = sda_pos_q & ~sda_i;
   assign stop_seen  = ~sda_pos_q & sda_i;
   assign byte_in    = {shift_q[6:0], sda_pos_q};
   assign nidx       = idx_q + 2'h1;

   always_comb begin
      state_d  = state_q;
      cnt_d    = cnt_q;
      shift_d  = shift_q;
      idx_d    = idx_q;
      oe_d     = oe_q;
      busy_d   = busy_q;
      stage_d  = stage_q;
      lk_ib1_d = lk_ib1_q;
      lk_ib2_d = lk_ib2_q;
      tgl_d    = tgl_q;
      if (start_seen) begin
         state_d = ACD_ADDR;
         cnt_d   = 4'h0;
         idx_d   = 2'h0;
         oe_d    = 1'b0;
         busy_d  = 1'b0;
      end else if (stop_seen) begin
         state_d = ACD_IDLE;
         oe_d    = 1'b0;
         busy_d  = 1'b0;
      end else begin
         unique case (state_q)
            ACD_IDLE: begin
               oe_d = 1'b0;
            end
            ACD_ADDR: begin
               if (cnt_q < `ACD_BIT_LAST) begin
                  shift_d = byte_in;
                  cnt_d   = cnt_q + 4'h1;
               end else if (cnt_q == `ACD_BIT_LAST) begin
                  shift_d = byte_in;
                  cnt_d   = `ACD_BIT_ACK;
                  if (byte_in[7:1] == ADDR_BYTE[7:1]) begin
                     oe_d   = 1'b1;
                     busy_d = byte_in[`ACD_RW_BIT];
                  end else begin
                     state_d = ACD_IDLE;
                  end
               end else begin
                  cnt_d = 4'h0;
                  idx_d = 2'h0;
                  if (shift_q[`ACD_RW_BIT]) begin
                     state_d = ACD_READ;
                     shift_d = snap_q[0];
                     oe_d    = ~snap_q[0][7];
                  end else begin
                     state_d = ACD_WRITE;
                     oe_d    = 1'b0;
                  end
               end
            end
            ACD_WRITE: begin
               if (cnt_q < `ACD_BIT_LAST) begin
                  shift_d = byte_in;
                  cnt_d   = cnt_q + 4'h1;
               end else if (cnt_q == `ACD_BIT_LAST) begin
                  cnt_d = `ACD_BIT_ACK;
                  // Bytes past the second are refused with no acknowledge
                  oe_d  = (idx_q < 2'(`ACD_WR_BYTES));
                  if (idx_q == 2'h0) begin
                     stage_d = byte_in;
                  end else if (idx_q == 2'h1) begin
                     lk_ib1_d = stage_q;
                     lk_ib2_d = byte_in;
                     tgl_d    = ~tgl_q;
                  end
               end else begin
                  cnt_d = 4'h0;
                  oe_d  = 1'b0;
                  if (idx_q < 2'(`ACD_WR_BYTES)) begin
                     idx_d = nidx;
                  end
               end
            end
            ACD_READ: begin
               if (cnt_q < `ACD_BIT_LAST) begin
                  shift_d = {shift_q[6:0], 1'b1};
                  oe_d    = ~shift_q[6];
                  cnt_d   = cnt_q + 4'h1;
               end else if (cnt_q == `ACD_BIT_LAST) begin
                  oe_d  = 1'b0;
                  cnt_d = `ACD_BIT_ACK;
               end else if (!sda_pos_q) begin
                  cnt_d = 4'h0;
                  if (idx_q < 2'(CHANNELS - 1)) begin
                     idx_d   = nidx;
                     shift_d = snap_q[nidx];
                     oe_d    = ~snap_q[nidx][7];
                  end else begin
                     shift_d = `ACD_FILL_BYTE;
                     oe_d    = 1'b0;
                  end
               end else begin
                  state_d = ACD_IDLE;
                  oe_d    = 1'b0;
                  busy_d  = 1'b0;
               end
            end
         endcase
      end
   end

   always_ff @(negedge link_scl) begin
      if (!lk_rst_n) begin
         state_q <= ACD_IDLE;
         cnt_q   <= 4'h0;
         shift_q <= 8'h00;
         idx_q   <= 2'h0;
      end else if (lk_ce) begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         shift_q <= shift_d;
         idx_q   <= idx_d;
      end
   end

   // Bus drive and read-in-progress level
   always_ff @(negedge link_scl) begin
      if (!lk_rst_n) begin
         oe_q   <= 1'b0;
         busy_q <= 1'b0;
      end else if (lk_ce) begin
         oe_q   <= oe_d;
         busy_q <= busy_d;
      end
   end

   // Instruction bytes are held here and announced by a toggle
   always_ff @(negedge link_scl) begin
      if (!lk_rst_n) begin
         stage_q  <= `ACD_IB1_RST;
         lk_ib1_q <= `ACD_IB1_RST;
         lk_ib2_q <= `ACD_IB2_RST;
         tgl_q    <= 1'b0;
      end else if (lk_ce) begin
         stage_q  <= stage_d;
         lk_ib1_q <= lk_ib1_d;
         lk_ib2_q <= lk_ib2_d;
         tgl_q    <= tgl_d;
      end
   end

   // Open-drain: only ever pulls low
   assign sda_o  = 1'b0;
   assign sda_oe = oe_q & out_en_q;

   // ---------------- System domain ----------------
   acd_sync #(.WIDTH(SYNC_W)) u_sys_sync (
      .clk (clk),
      .en  (ce),
      .d   ({fault_i, thermal_warn_i, turnon_done_i, clip_raw_i, offset_raw_i,
             tgl_q, busy_q}),
      .q   (sync_q)
   );

   assign flt_s   = sync_q[SYNC_W-1 -: FLT_W];
   assign therm_s = sync_q[5];
   assign done_s  = sync_q[4];
   assign clip_s  = sync_q[3];
   assign ofs_s   = sync_q[2];
   assign tgl_s   = sync_q[1];
   assign busy_s  = sync_q[0];
   assign read_end = busy_prev_q & ~busy_s;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         out_en_q    <= 1'b0;
         tgl_seen_q  <= 1'b0;
         busy_prev_q <= 1'b0;
      end else if (ce) begin
         out_en_q    <= 1'b1;
         tgl_seen_q  <= tgl_s;
         busy_prev_q <= busy_s;
      end
   end

   // The link words stay still for a whole frame after the toggle moves
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ib1_q <= `ACD_IB1_RST;
         ib2_q <= `ACD_IB2_RST;
      end else if (ce && (tgl_s != tgl_seen_q)) begin
         ib1_q <= lk_ib1_q;
         ib2_q <= lk_ib2_q;
      end
   end

   assign ctrl_o = acd_ctrl_t'({ib1_q, ib2_q});

   always_ff @(posedge clk) begin
      if (!resetn) begin
         clip_detector <= 1'b0;
      end else if (ce) begin
         clip_detector <= ib2_q[`ACD_IB2_PIN_OFS] ? ofs_s : clip_s;
      end
   end

   // Terminated only when the turn-on cycle was enabled and has finished
   assign diag_done = ib1_q[`ACD_IB1_DIAG_EN] & done_s;

   function automatic logic [7:0] db_byte(acd_fault_t f, logic [7:0] ib1,
                                          logic [7:0] ib2, logic fin,
                                          logic seen);
      logic       perm;
      logic       dual;
      logic [7:0] b;
      perm = ~ib1[`ACD_IB1_DIAG_EN] | fin;
      dual = perm & f.short_gnd & f.short_vcc;
      b    = `ACD_DB_RST;
      b[`ACD_DB_CUR]   = f.cur_low & ib2[`ACD_IB2_CUR_EN];
      b[`ACD_DB_SRC]   = perm;
      b[`ACD_DB_SLOAD] = f.short_load;
      b[`ACD_DB_OPEN]  = perm ? (f.offset & ib1[`ACD_IB1_OFS_EN]) : f.open_load;
      b[`ACD_DB_SVCC]  = f.short_vcc & ~dual;
      b[`ACD_DB_SGND]  = f.short_gnd & ~(dual & seen);
      return b;
   endfunction : db_byte

   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
         logic [7:0] base;
         assign base = db_byte(flt_s[ch], ib1_q, ib2_q, diag_done, seen_q[ch]);
         if (ch == 0) begin : g_first
            always_comb begin
               db_now[ch]                = base;
               db_now[ch][`ACD_DB_THERM] = therm_s;
               db_now[ch][`ACD_DB_DONE]  = diag_done;
            end
         end else begin : g_rest
            assign db_now[ch] = base;
         end

         // Outside a running turn-on cycle, a dual short is reported as ground once, then hidden until it clears
         always_ff @(posedge clk) begin
            if (!resetn) begin
               seen_q[ch] <= 1'b0;
            end else if (ce) begin
               if (!(flt_s[ch].short_gnd && flt_s[ch].short_vcc)) begin
                  seen_q[ch] <= 1'b0;
               end else if (read_end) begin
                  seen_q[ch] <= 1'b1;
               end
            end
         end

         // Frozen while a read is in progress so the link sees stable bytes
         always_ff @(posedge clk) begin
            if (!resetn) begin
               snap_q[ch] <= `ACD_DB_RST;
            end else if (ce && !busy_s) begin
               snap_q[ch] <= db_now[ch];
            end
         end
      end
   endgenerate

endmodule : acd_port

/* acd_sync.sv */
`timescale 1ns/1ps
module acd_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             en,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (en) begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : acd_sync

/* tb.sv */
`timescale 1ns/1ps
module tb;
   import acd_pkg::*;
   logic             clk, resetn, ce, link_scl, sda_drv, sda_w, sda_oe;
   logic             thermal_warn_i, turnon_done_i, clip_raw_i, offset_raw_i;
   logic             clip_detector;
   acd_fault_t [3:0] fault_i;
   acd_ctrl_t        ctrl_o;
   logic [7:0]       db [0:4];
   int               num_errors = 0;
   int               total_checks = 0;
   int               cycles = 0;
   assign sda_w = sda_drv & ~sda_oe;
   acd_port #(.CHANNELS(4)) dut_u (
      .clk(clk), .resetn(resetn), .ce(ce), .link_scl(link_scl), .sda_i(sda_w),
      .sda_o(), .sda_oe(sda_oe), .fault_i(fault_i), .thermal_warn_i(thermal_warn_i),
      .turnon_done_i(turnon_done_i), .clip_raw_i(clip_raw_i),
      .offset_raw_i(offset_raw_i), .ctrl_o(ctrl_o), .clip_detector(clip_detector));
   acd_host host_u (.scl(link_scl), .sda_drv(sda_drv), .sda(sda_w));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude
   // Whole run needs well under ten thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles > 30000) begin
         num_errors++;
         $display("wrong value at %0t: timeout", $time);
         conclude();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, b1, b2, input logic [2:0] ex);
      logic [2:0] ak;
      host_u.start_cond();
      host_u.send_byte(a, ak[2]);
      host_u.send_byte(b1, ak[1]);
      host_u.send_byte(b2, ak[0]);
      host_u.stop_cond();
      repeat (5) @(posedge clk);
      #1 chk(16'(ak), 16'(ex), "acks");
   endtask : wr
   task automatic rd(input int n);
      logic a;
      host_u.start_cond();
      host_u.send_byte(8'hD9, a);
      chk(16'(a), 16'h0001, "read address ack");
      for (int i = 0; i < n; i++) host_u.recv_byte(i < n - 1, db[i]);
      host_u.stop_cond();
   endtask : rd
   // Link reset passes through bus clock flops, so the bus clock runs during reset
   task automatic t_reset();
      @(posedge clk);
      #1 resetn = 1'b0;
      host_u.idle_clocks(3);
      @(posedge clk);
      #1 resetn = 1'b1;
      host_u.idle_clocks(3);
      chk(16'(ctrl_o), 16'h0000, "ctrl reset");
      chk(16'(clip_detector), 16'h0000, "indicator reset");
      chk(16'(sda_oe), 16'h0000, "drive reset");
      $display("test reset done");
   endtask : t_reset
   task automatic t_write();
      logic [7:0] b;
      for (int i = 0; i < 2; i++) begin
         b = i ? 8'h5A : 8'hA5;
         wr(8'hD8, b, ~b, 3'b111);
         chk(16'(ctrl_o), {b, ~b}, "ctrl");
      end
      $display("test write done");
   endtask : t_write
   task automatic t_refuse();
      logic [7:0] bad [3] = '{8'h58, 8'hD0, 8'hDA};
      logic a;
      foreach (bad[i]) begin
         wr(bad[i], 8'hFF, 8'hFF, 3'b000);
         chk(16'(ctrl_o), 16'h5AA5, "foreign address");
      end
      host_u.start_cond();
      host_u.send_byte(8'hD8, a);
      host_u.send_byte(8'h12, a);
      host_u.send_byte(8'h34, a);
      host_u.send_byte(8'h56, a);
      chk(16'(a), 16'h0000, "extra byte ack");
      host_u.stop_cond();
      chk(16'(ctrl_o), 16'h1234, "extra byte");
      host_u.start_cond();
      host_u.send_byte(8'hD8, a);
      host_u.send_byte(8'h77, a);
      host_u.stop_cond();
      chk(16'(ctrl_o), 16'h1234, "lone byte");
      $display("test refuse done");
   endtask : t_refuse
   task automatic t_perm();
      logic [7:0] ex [5] = '{8'hFC, 8'h11, 8'h12, 8'h10, 8'hFF};
      wr(8'hD8, 8'h60, 8'h14, 3'b111);
      fault_i = {6'h00, 6'h10, 6'h20, 6'h0F};
      thermal_warn_i = 1'b1;
      turnon_done_i = 1'b1;
      rd(5);
      foreach (ex[i]) chk(16'(db[i]), 16'(ex[i]), "diag byte");
      $display("test permanent done");
   endtask : t_perm
   task automatic t_turnon();
      wr(8'hD8, 8'h40, 8'h10, 3'b111);
      fault_i = {18'h0, 6'h07};
      thermal_warn_i = 1'b0;
      turnon_done_i = 1'b0;
      rd(1);
      chk(16'(db[0]), 16'h0004, "turn-on running");
      turnon_done_i = 1'b1;
      rd(1);
      chk(16'(db[0]), 16'h0050, "turn-on finished");
      $display("test turn-on done");
   endtask : t_turnon
   task automatic t_dual();
      wr(8'hD8, 8'h00, 8'h10, 3'b111);
      fault_i = {18'h0, 6'h30};
      for (int i = 0; i < 3; i++) begin
         rd(1);
         chk(16'(db[0]), i ? 16'h0010 : 16'h0011, "dual short");
      end
      $display("test dual short done");
   endtask : t_dual
   task automatic t_clip();
      for (int s = 0; s < 2; s++) begin
         wr(8'hD8, 8'h00, s ? 8'h20 : 8'h00, 3'b111);
         for (int v = 0; v < 4; v++) begin
            clip_raw_i = v[1];
            offset_raw_i = v[0];
            repeat (6) @(posedge clk);
            #1 chk(16'(clip_detector), 16'(s ? v[0] : v[1]), "indicator");
         end
      end
      // Enable low must freeze the indicator path
      ce = 1'b0;
      offset_raw_i = 1'b0;
      repeat (6) @(posedge clk);
      #1 chk(16'(clip_detector), 16'h0001, "frozen indicator");
      ce = 1'b1;
      repeat (6) @(posedge clk);
      #1 chk(16'(clip_detector), 16'h0000, "released indicator");
      $display("test indicator done");
   endtask : t_clip
   initial begin
      resetn = 1'b0;
      ce = 1'b1;
      thermal_warn_i = 1'b0;
      turnon_done_i = 1'b0;
      clip_raw_i = 1'b0;
      offset_raw_i = 1'b0;
      fault_i = '0;
      t_reset();
      t_write();
      t_refuse();
      t_reset();
      t_perm();
      t_turnon();
      t_dual();
      t_clip();
      conclude();
   end
endmodule : tb
